// File: iicm_ctrl.sv
// iicm_ctrl.sv: two-wire bus master engine with its register file
// assumes open-drain lines with pull-ups and an avalon-mm master on clock_i
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`include "iicm_defs.svh"
`default_nettype none
module iicm_ctrl
  import iicm_pkg::*;
#(
  parameter int HALF_TICKS = `IICM_HALF_TICKS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam int ALLOW_BASE = `IICM_ALLOW_CYC(`IICM_ALLOW_BASE_X10);
  localparam int ALLOW_EXT = `IICM_ALLOW_CYC(`IICM_ALLOW_EXT_X10);
  localparam int ALLOW_DBL = `IICM_ALLOW_CYC(`IICM_ALLOW_DBL_X10);

  logic scl_s;
  logic sda_s;
  logic tick;
  logic ack_r;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] ctrl_r;
  logic [7:0] data_r;
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic [7:0] cnt_r;
  logic [7:0] rise_r;
  logic [7:0] allow;
  logic irq_r;
  logic ackb_r;
  logic busy_r;
  logic scl_seen_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_drv_r;
  logic sda_drv_r;
  logic launch;
  logic start_req;
  logic stop_req;
  logic tx_mode;
  logic byte_end;
  logic ninth_rise;
  logic own_bus;
  iicm_state_e st_r;

  iicm_sync u_scl_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(scl_i),
    .level_o(scl_s)
  );

  iicm_sync u_sda_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(sda_i),
    .level_o(sda_s)
  );

  iicm_tick #(
    .DIV(`IICM_TICK_CYC)
  ) u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // one wait cycle, then the access is taken
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign acc = (avs_read_i | avs_write_i) & ack_r;
  assign wr_acc = acc & avs_write_i;
  assign rd_acc = acc & avs_read_i;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (avs_read_i & ~ack_r)
    begin
      if (hit(avs_address_i, `IICM_OFS_CTRL))
        avs_readdata_o <= {24'h000000, ctrl_r};
      else if (hit(avs_address_i, `IICM_OFS_STAT))
        avs_readdata_o <= {24'h000000, busy_r | own_bus, irq_r, 1'b1,
                           4'h0, ackb_r};
      else if (hit(avs_address_i, `IICM_OFS_DATA))
        avs_readdata_o <= {24'h000000, data_r};
      else if (hit(avs_address_i, `IICM_OFS_LINE))
        avs_readdata_o <= {30'h00000000, scl_s, sda_s};
      else
        avs_readdata_o <= 32'h00000000;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_r <= `IICM_CTRL_RST;
    else if (wr_acc & hit(avs_address_i, `IICM_OFS_CTRL))
      ctrl_r <= avs_writedata_i[7:0];
  end

  assign tx_mode = ctrl_r[`IICM_CB_TX];
  assign own_bus = (st_r != ST_IDLE);

  // direction comes from the control transmit bit; the access kind must match it
  assign launch = (st_r == ST_WAIT) & ctrl_r[`IICM_CB_ENABLE]
    & hit(avs_address_i, `IICM_OFS_DATA)
    & ((wr_acc & tx_mode)
    | (rd_acc & ~tx_mode));

  assign start_req = wr_acc & hit(avs_address_i, `IICM_OFS_STAT)
    & ctrl_r[`IICM_CB_ENABLE] & ctrl_r[`IICM_CB_MASTER]
    & avs_writedata_i[`IICM_SB_BUSY] & ~avs_writedata_i[`IICM_SB_SCP]
    & (((st_r == ST_IDLE) & ~busy_r) | (st_r == ST_WAIT));
  assign stop_req = wr_acc & hit(avs_address_i, `IICM_OFS_STAT)
    & ~avs_writedata_i[`IICM_SB_BUSY] & ~avs_writedata_i[`IICM_SB_SCP]
    & (st_r == ST_WAIT);

  // rise allowance picked by halving and rate extension
  always_comb
  begin
    if (ctrl_r[`IICM_CB_EXTEND] & ctrl_r[`IICM_CB_HALVE])
      allow = 8'(ALLOW_DBL);
    else if (ctrl_r[`IICM_CB_EXTEND])
      allow = 8'(ALLOW_EXT);
    else
      allow = 8'(ALLOW_BASE);
  end

  assign ninth_rise = (st_r == ST_HIGH) & scl_s & ~scl_seen_r
    & (bit_r == 4'h8);
  assign byte_end = (st_r == ST_HIGH) & scl_seen_r & tick
    & (cnt_r == 8'(HALF_TICKS - 1)) & (bit_r == 4'h8);

  // bus busy follows start and stop seen on the lines
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (scl_s & scl_d_r & sda_d_r & ~sda_s)
        busy_r <= 1'b1;
      else if (scl_s & scl_d_r & ~sda_d_r & sda_s)
        busy_r <= 1'b0;
    end
  end

  // set at the ninth rise wins over a clearing write
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else if (ninth_rise)
      irq_r <= 1'b1;
    else if (wr_acc & hit(avs_address_i, `IICM_OFS_STAT)
             & ~avs_writedata_i[`IICM_SB_IRQ])
      irq_r <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      ackb_r <= 1'b0;
    else if (ninth_rise & tx_mode)
      ackb_r <= sda_s;
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      data_r <= 8'h00;
    else if (byte_end & ~tx_mode)
      data_r <= shift_r;
    else if (wr_acc & hit(avs_address_i, `IICM_OFS_DATA))
      data_r <= avs_writedata_i[7:0];
  end

  // clock rise timing: stall the high count past the allowance
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rise_r <= 8'h00;
      scl_seen_r <= 1'b0;
    end
    else if (st_r != ST_HIGH)
    begin
      rise_r <= 8'h00;
      scl_seen_r <= 1'b0;
    end
    else
    begin
      if (scl_s)
        scl_seen_r <= 1'b1;
      else if (rise_r != 8'hff)
        rise_r <= rise_r + 8'h01;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          scl_drv_r <= 1'b0;
          sda_drv_r <= 1'b0;
          cnt_r <= 8'h00;
          if (start_req)
          begin
            sda_drv_r <= 1'b1;
            st_r <= ST_START;
          end
        end
        ST_START:
        begin
          if (~sda_drv_r)
          begin
            // repeated start: release both, then drop data under high clock
            if (tick)
              cnt_r <= cnt_r + 8'h01;
            if (cnt_r >= 8'(HALF_TICKS))
              scl_drv_r <= 1'b0;
            if (~scl_drv_r & scl_s)
            begin
              sda_drv_r <= 1'b1;
              cnt_r <= 8'h00;
            end
          end
          else if (tick)
          begin
            if (cnt_r == 8'(HALF_TICKS - 1))
            begin
              scl_drv_r <= 1'b1;
              cnt_r <= 8'h00;
              st_r <= ST_WAIT;
            end
            else
              cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_WAIT:
        begin
          scl_drv_r <= 1'b1;
          cnt_r <= 8'h00;
          if (launch)
          begin
            bit_r <= 4'h0;
            shift_r <= tx_mode ? avs_writedata_i[7:0] : 8'h00;
            st_r <= ST_LOW;
          end
          else if (stop_req)
          begin
            sda_drv_r <= 1'b1;
            st_r <= ST_STOP;
          end
          else if (start_req)
          begin
            sda_drv_r <= 1'b0;
            st_r <= ST_START;
          end
        end
        ST_LOW:
        begin
          if (tick)
          begin
            if (cnt_r == 8'h00)
            begin
              if (bit_r == 4'h8)
                sda_drv_r <= ~tx_mode & ~ctrl_r[`IICM_CB_NOACK];
              else
                sda_drv_r <= tx_mode & ~shift_r[7];
            end
            if (cnt_r == 8'(HALF_TICKS - 1))
            begin
              scl_drv_r <= 1'b0;
              cnt_r <= 8'h00;
              st_r <= ST_HIGH;
            end
            else
              cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_HIGH:
        begin
          if (scl_s & ~scl_seen_r & (bit_r != 4'h8))
            shift_r <= tx_mode ? shift_r : {shift_r[6:0], sda_s};
          // slow rise: hold the count so the high time grows
          if (tick & (scl_seen_r | (rise_r < allow)))
          begin
            if (cnt_r < 8'(HALF_TICKS - 1))
              cnt_r <= cnt_r + 8'h01;
            else if (scl_seen_r)
            begin
              scl_drv_r <= 1'b1;
              cnt_r <= 8'h00;
              if (bit_r == 4'h8)
                st_r <= ST_WAIT;
              else
              begin
                bit_r <= bit_r + 4'h1;
                shift_r <= tx_mode ? {shift_r[6:0], 1'b1} : shift_r;
                st_r <= ST_LOW;
              end
            end
          end
        end
        ST_STOP:
        begin
          if (tick)
            cnt_r <= cnt_r + 8'h01;
          if (cnt_r >= 8'(HALF_TICKS))
            scl_drv_r <= 1'b0;
          if (~scl_drv_r & scl_s & (cnt_r >= 8'(2 * HALF_TICKS)))
          begin
            sda_drv_r <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drv_r;
  assign sda_oe_o = sda_drv_r;
endmodule : iicm_ctrl
`default_nettype wire

// File: iicm_ctrl_checker.sv
// iicm_ctrl_checker.sv: port assertions on iicm_ctrl
// assumes pulled-up lines and HALF_TICKS handed on by the bind
`default_nettype none
module iicm_ctrl_checker #(
  parameter int HALF_TICKS = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic scl_i,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GO_MAX = HALF_TICKS * 25 + 60;
  localparam int END_MAX = HALF_TICKS * 100 + 100;
  localparam int MIN_HIGH = (HALF_TICKS - 1) * 25 - 10;
  logic [7:0] ctl_r;
  int hi_r;
  logic wr_t;
  logic rd_t;
  logic dat_a;
  logic st_w;
  assign wr_t = avs_write_i && !avs_waitrequest_o;
  assign rd_t = avs_read_i && !avs_waitrequest_o;
  assign dat_a = avs_address_i == 4'h8;
  assign st_w = wr_t && avs_address_i == 4'h4;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // shadow of the control byte
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      ctl_r <= 8'h00;
    else if (wr_t && avs_address_i == 4'h0)
      ctl_r <= avs_writedata_i[7:0];
  // cycles the clock line has been high
  always_ff @(posedge clock_i or posedge rst_i)
    if (rst_i)
      hi_r <= 0;
    else
      hi_r <= scl_i ? hi_r + 1 : 0;
  a_wait_once: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest not one cycle");
  a_unmapped_zero: assert property (rd_t && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_tx_launch: assert property (
    wr_t && dat_a && ctl_r[7] && ctl_r[4] && scl_oe_o
    |-> ##[1:GO_MAX] !scl_oe_o)
    else $error("data write launched no byte");
  a_rx_launch: assert property (
    rd_t && dat_a && ctl_r[7] && !ctl_r[4] && scl_oe_o
    |-> ##[1:GO_MAX] !scl_oe_o)
    else $error("data read launched no byte");
  a_off_quiet: assert property (
    (wr_t || rd_t) && dat_a && !ctl_r[7] && !scl_oe_o
    |=> !scl_oe_o [*8])
    else $error("disabled access moved the clock");
  a_start_cond: assert property (
    st_w && avs_writedata_i[7:5] == 3'b100 && ctl_r[7] && ctl_r[5]
    && scl_i && sda_i && !scl_oe_o
    |-> ##[1:GO_MAX] (sda_oe_o && !scl_oe_o))
    else $error("no start condition");
  a_stop_cond: assert property (
    st_w && avs_writedata_i[7:5] == 3'b000 && scl_oe_o
    |-> ##[1:END_MAX] (scl_i && sda_i && !scl_oe_o && !sda_oe_o))
    else $error("no stop condition");
  a_high_span: assert property (
    $rose(scl_oe_o) |-> hi_r >= MIN_HIGH)
    else $error("clock high time cut short");
  a_drain_low: assert property (!scl_o && !sda_o)
    else $error("open-drain output driven high");
endmodule : iicm_ctrl_checker
bind iicm_ctrl iicm_ctrl_checker #(.HALF_TICKS(HALF_TICKS))
  iicm_ctrl_checker_i (
  .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_i),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
  .scl_o(scl_o), .sda_o(sda_o)
);
`default_nettype wire

// File: iicm_defs.svh
// iicm_defs.svh: register offsets, field positions, reset values, timing
// assumes a 200 MHz system clock and byte addresses on the register bus
// How it works
// - with the interface enabled and transmit selected, a data write starts the next byte.
// - with the interface enabled and receive selected, a data read starts the next byte.
// - as master the engine watches the real clock line and syncs on every bit.
// - a clock rise slower than 7.5, 17.5 or 37.5 cycles lengthens the high time.
// - busy written 1 with control 0 makes a start, both 0 make a stop.
// - the transfer flag sets at the ninth clock rise and the clock is held low until service.
`ifndef IICM_DEFS_SVH
`define IICM_DEFS_SVH
`define IICM_OFS_CTRL 4'h0
`define IICM_OFS_STAT 4'h4
`define IICM_OFS_DATA 4'h8
`define IICM_OFS_LINE 4'hc
`define IICM_CTRL_RST 8'h00
`define IICM_CB_ENABLE 7
`define IICM_CB_MASTER 5
`define IICM_CB_TX 4
`define IICM_CB_HALVE 3
`define IICM_CB_EXTEND 2
`define IICM_CB_NOACK 1
`define IICM_SB_BUSY 7
`define IICM_SB_IRQ 6
`define IICM_SB_SCP 5
`define IICM_SB_ACKB 0
`define IICM_TICK_NS 125
`define IICM_CLK_NS 5
`define IICM_TICK_CYC (`IICM_TICK_NS / `IICM_CLK_NS)
`define IICM_HALF_TICKS 20
`define IICM_ALLOW_BASE_X10 75
`define IICM_ALLOW_EXT_X10 175
`define IICM_ALLOW_DBL_X10 375
`define IICM_ALLOW_CYC(x) (((x) + 9) / 10)
`endif

// File: iicm_peer.sv
// iicm_peer.sv: behavioural slave on the two-wire bus
// assumes pulled-up lines; it only pulls them low
`default_nettype none
module iicm_peer (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [15:0] stretch_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos = 0;
  int nbyte = 0;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic talk = 1'b0;
  logic [7:0] sh = 8'h00;
  initial
  begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    rx_byte_o = 8'h00;
    done_o = 1'b0;
  end
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      act = 1'b1;
      pos = 0;
      nbyte = 0;
      rd = 1'b0;
      talk = 1'b0;
    end
  always @(posedge sda_i)
    if (scl_i === 1'b1)
      act = 1'b0;
  // drive data or ack after each fall, then stretch the low time
  always @(negedge scl_i)
    if (act)
    begin
      pos = pos % 9 + 1;
      sda_oe_o = (pos == 9) ? !rd : talk && !tx_byte_i[8 - pos];
      if (stretch_i != 16'h0)
      begin
        scl_oe_o = 1'b1;
        #(stretch_i);
        scl_oe_o = 1'b0;
      end
    end
  always @(posedge scl_i)
    if (act && pos > 0)
    begin
      if (pos < 9)
        sh = {sh[6:0], sda_i};
      else
      begin
        if (!rd)
        begin
          rx_byte_o = sh;
          done_o = 1'b1;
        end
        if (nbyte == 0)
          rd = sh[0];
        talk = rd && (nbyte == 0 || !sda_i);
        nbyte = nbyte + 1;
        #5;
        done_o = 1'b0;
      end
    end
endmodule : iicm_peer
`default_nettype wire

// File: iicm_pkg.sv
// iicm_pkg.sv: types shared by the two-wire controller
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package iicm_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_WAIT = 6'h04,
    ST_LOW = 6'h08,
    ST_HIGH = 6'h10,
    ST_STOP = 6'h20
  } iicm_state_e;
endpackage : iicm_pkg
`default_nettype wire

// File: iicm_sync.sv
// iicm_sync.sv: pin synchroniser with a match filter
// assumes an asynchronous pin level on pin_i
`default_nettype none
module iicm_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // level moves only when two samples agree
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      level_o <= 1'b1;
    else if (s2_r == s3_r)
      level_o <= s3_r;
  end
endmodule : iicm_sync
`default_nettype wire

// File: iicm_tick.sv
// iicm_tick.sv: divider giving a one-cycle enable pulse
// assumes DIV of at least 2
`default_nettype none
module iicm_tick #(
  parameter int DIV = 25
) (
  input wire logic clock_i,
  input wire logic rst_i,
  output logic tick_o
);
  logic [15:0] cnt_r;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt_r == 16'(DIV - 1))
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : iicm_tick
`default_nettype wire

// File: tb.sv
// tb.sv: self-checking bench for iicm_ctrl with a slave model
// assumes HALF_TICKS of 4, about 1800 to 2700 cycles a byte
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i;
  logic rst_i;
  logic [3:0] addr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wreq;
  logic m_scl_oe;
  logic m_sda_oe;
  logic p_scl_oe;
  logic p_sda_oe;
  logic scl;
  logic sda;
  logic [7:0] tx_byte;
  logic [15:0] stretch;
  logic [7:0] rx_byte;
  logic done;
  logic [7:0] b;
  logic [31:0] m;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] byte_q[$];
  int seed;
  int mismatches;
  int check_count;
  assign scl = !(m_scl_oe || p_scl_oe);
  assign sda = !(m_sda_oe || p_sda_oe);
  iicm_ctrl #(.HALF_TICKS(4)) iicm_ctrl_i (
    .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .scl_i(scl),
    .scl_o(), .scl_oe_o(m_scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe_o(m_sda_oe));
  iicm_peer iicm_peer_i (.scl_i(scl), .sda_i(sda), .tx_byte_i(tx_byte),
    .stretch_i(stretch), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe),
    .rx_byte_o(rx_byte), .done_o(done));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic bus(input logic [3:0] a, input logic w,
    input logic [31:0] d, input logic [31:0] mk, input logic [31:0] ex);
    if (!w)
    begin
      exp_q.push_back(ex);
      msk_q.push_back(mk);
    end
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock_i);
    while (wreq !== 1'b0)
      @(posedge clock_i);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0, 32'h0);
  endtask : put
  task automatic get(input logic [3:0] a, input logic [31:0] mk,
    input logic [31:0] ex);
    bus(a, 1'b0, 32'h0, mk, ex);
  endtask : get
  task automatic poll(input logic [3:0] a, input int n, input logic v);
    do
      get(a, 32'h0, 32'h0);
    while (rdata[n] !== v);
  endtask : poll
  // compare read data at the taken edge
  always @(posedge clock_i)
    if (rd === 1'b1 && wreq === 1'b0 && exp_q.size() > 0)
    begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      if (m != 32'h0)
        check(rdata & m, e);
    end
  always @(posedge done)
    check({24'h0, rx_byte}, {24'h0, byte_q.pop_front()});
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end
  initial
  begin
    seed = 1;
    mismatches = 0;
    check_count = 0;
    rst_i = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    tx_byte = 8'h00;
    stretch = 16'h0;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    get(4'h0, 32'hffffffff, 32'h0);
    get(4'h4, 32'hffffffff, 32'h20);
    put(4'h2, 32'h5a);
    get(4'h2, 32'hffffffff, 32'h0);
    put(4'h8, 32'h3c);
    get(4'h8, 32'hff, 32'h3c);
    repeat (50) @(posedge clock_i);
    get(4'hc, 32'h3, 32'h3);
    $display("test idle done");
    for (int k = 0; k < 4; k++)
    begin
      stretch <= (k == 0) ? 16'd30 : 16'd1000;
      put(4'h0, 32'hb0 | (k << 2));
      put(4'h4, 32'h80);
      poll(4'hc, 1, 1'b0);
      get(4'hc, 32'h3, 32'h0);
      for (int j = 0; j < 2; j++)
      begin
        b = 8'($random(seed)) & 8'hfe;
        byte_q.push_back(b);
        put(4'h4, 32'ha0);
        put(4'h8, {24'h0, b});
        poll(4'h4, 6, 1'b1);
        repeat (150) @(posedge clock_i);
        get(4'hc, 32'h2, 32'h0);
        get(4'h4, 32'h61, 32'h60);
      end
      put(4'h4, 32'h00);
      poll(4'h4, 7, 1'b0);
      get(4'hc, 32'h3, 32'h3);
      $display("test transmit %0d done", k);
    end
    stretch <= 16'h0;
    tx_byte <= 8'($random(seed));
    put(4'h0, 32'hb0);
    put(4'h4, 32'h80);
    poll(4'hc, 1, 1'b0);
    byte_q.push_back(8'h91);
    put(4'h8, 32'h91);
    poll(4'h4, 6, 1'b1);
    poll(4'hc, 1, 1'b0);
    put(4'h0, 32'ha2);
    put(4'h4, 32'ha0);
    get(4'h8, 32'h0, 32'h0);
    poll(4'h4, 6, 1'b1);
    poll(4'hc, 1, 1'b0);
    put(4'h0, 32'hb2);
    get(4'h8, 32'hff, {24'h0, tx_byte});
    put(4'h4, 32'h80);
    poll(4'hc, 1, 1'b1);
    poll(4'hc, 1, 1'b0);
    byte_q.push_back(8'h90);
    put(4'h8, 32'h90);
    poll(4'h4, 6, 1'b1);
    get(4'h4, 32'h61, 32'h60);
    poll(4'hc, 1, 1'b0);
    put(4'h4, 32'h00);
    poll(4'h4, 7, 1'b0);
    $display("test receive done");
    close_out();
  end
endmodule : tb
`default_nettype wire
